// File: hw/bsv_loader.sv
/*
 * Boot strap vector loader. Samples the strap data bus during cold reset,
 * decodes the boot configuration and holds it for the rest of operation,
 * keeps the raw vector for software and stretches the system reset output.
 * Assumes all inputs are synchronous to i_core_clk and that the strap source
 * drives a defined vector while the cold reset input is low.
 */
// What this block does
// - Sample the sixteen-bit strap bus as boot vector while cold reset is low.
// - Hold decoded configuration stable from cold reset release onward.
// - Bits 2:0 pick PLL multiplier; 0 means times two, others reserved.
// - Bit 3 picks byte order: zero little endian, one big endian.
// - Bit 4 has no function but is kept in the raw vector field.
// - Bits 6:5 pick boot width: 8, 16, 32 bits, code 3 reserved.
// - Bit 7 zero keeps system reset output asserted at least 4096 cycles.
// - Bit 8 set brings the watchdog out of cold reset disabled.
// - Bits 11:9 pick PCI mode: off, two satellite, three host modes.
// - PCI enable resets to one only for PCI modes 1 and 2.
// - Bits 15:12 have no function but are kept in the raw vector field.
`timescale 1ns/100ps
module bsv_loader
    import bsv_pkg::*;
#(
    parameter int HOLD_CYCLES = RST_HOLD_CYCLES
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_srst,
    input  wire logic              i_cold_reset_input_n,
    input  wire logic [VEC_W-1:0]  i_strap_data_bus,
    input  wire logic [ADDR_W-1:0] i_reg_addr,
    input  wire logic [DATA_W-1:0] i_reg_wdata,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    output logic [DATA_W-1:0]      o_reg_rdata,
    output logic [PLL_W-1:0]       o_pll_mult,
    output logic                   o_big_endian,
    output logic [WIDTH_W-1:0]     o_boot_width,
    output logic                   o_wdt_disable,
    output logic [PCI_W-1:0]       o_pci_mode,
    output logic                   o_pci_en,
    output logic                   o_cfg_valid,
    output logic                   o_system_reset_output_n
);

    bsv_top_s         s_r;
    bsv_top_s         s_nxt;
    logic             sys_rst_n;
    logic             release_now;
    logic [PCI_W-1:0] vec_pci;

    // Release is the first cycle cold reset is seen high after sampling
    assign release_now = (s_r.st == ST_SAMPLE) && i_cold_reset_input_n;
    assign vec_pci     = s_r.vec[PCI_LSB +: PCI_W];

    always_comb begin
        s_nxt       = s_r;
        s_nxt.rdata = '0;

        // Software may flip the PCI enable at any time after boot
        if (i_reg_wr && i_reg_addr == REG_PCI_CTL) begin
            s_nxt.pci_en = i_reg_wdata[PCI_EN_BIT];
        end

        case (s_r.st)
            ST_WAIT: begin
                if (!i_cold_reset_input_n) begin
                    s_nxt.st  = ST_SAMPLE;
                    s_nxt.vec = i_strap_data_bus;
                end
            end
            ST_SAMPLE: begin
                if (!i_cold_reset_input_n) begin
                    // Last sample before release is the one decoded
                    s_nxt.vec = i_strap_data_bus;
                end else begin
                    s_nxt.st      = ST_RUN;
                    s_nxt.valid   = 1'b1;
                    s_nxt.pll     = s_r.vec[PLL_LSB +: PLL_W];
                    s_nxt.big     = s_r.vec[ENDIAN_BIT];
                    s_nxt.width   = s_r.vec[WIDTH_LSB +: WIDTH_W];
                    s_nxt.rstmode = s_r.vec[RSTMODE_BIT];
                    s_nxt.wdt     = s_r.vec[WDT_BIT];
                    s_nxt.pci     = vec_pci;
                    // Boot value wins over a same-cycle software write
                    s_nxt.pci_en  = (vec_pci == PCI_SAT_NRDY) || (vec_pci == PCI_SAT_SUSP);
                    s_nxt.rsvd[0] = s_r.vec[PLL_LSB +: PLL_W] != PLL_X2;
                    s_nxt.rsvd[1] = s_r.vec[WIDTH_LSB +: WIDTH_W] == WIDTH_RSVD;
                    s_nxt.rsvd[2] = s_r.vec[RSTMODE_BIT] == RSTMODE_RSVD;
                    s_nxt.rsvd[3] = vec_pci > PCI_HOST_RR;
                end
            end
            ST_RUN: begin
                // Decoded fields stay untouched here
                if (!i_cold_reset_input_n) begin
                    s_nxt.st    = ST_SAMPLE;
                    s_nxt.valid = 1'b0;
                    s_nxt.vec   = i_strap_data_bus;
                end
            end
            default: begin
                s_nxt.st = ST_WAIT;
            end
        endcase

        if (i_reg_rd) begin
            case (i_reg_addr)
                REG_RAW: begin
                    // Spare bits reach software only through here
                    s_nxt.rdata = DATA_W'(s_r.vec);
                end
                REG_CFG: begin
                    s_nxt.rdata = DATA_W'({s_r.pci, s_r.wdt, s_r.rstmode, s_r.width,
                                           1'b0, s_r.big, s_r.pll});
                end
                REG_PCI_CTL: begin
                    s_nxt.rdata = DATA_W'(s_r.pci_en);
                end
                REG_STATUS: begin
                    s_nxt.rdata = DATA_W'({!sys_rst_n, s_r.rsvd, s_r.valid});
                end
                default: begin
                    s_nxt.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Reset-mode bit 1 is reserved; treated as normal stretch
    bsv_rst_stretch #(
        .HOLD_CYCLES (RST_CNT_W'(HOLD_CYCLES))
    ) u_rst_stretch (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_hold     (s_r.st != ST_RUN),
        .o_rst_n    (sys_rst_n)
    );

    assign o_reg_rdata             = s_r.rdata;
    assign o_pll_mult              = s_r.pll;
    assign o_big_endian            = s_r.big;
    assign o_boot_width            = s_r.width;
    assign o_wdt_disable           = s_r.wdt;
    assign o_pci_mode              = s_r.pci;
    assign o_pci_en                = s_r.pci_en;
    assign o_cfg_valid             = s_r.valid;
    assign o_system_reset_output_n = sys_rst_n;

    property p_capture;
        @(posedge i_core_clk) disable iff (i_srst)
        !i_cold_reset_input_n |=> s_r.vec == $past(i_strap_data_bus);
    endproperty
    a_capture: assert property (p_capture)
        else $error("strap bus not captured during cold reset");

    property p_stable;
        @(posedge i_core_clk) disable iff (i_srst)
        (s_r.st == ST_RUN && i_cold_reset_input_n)
            |=> $stable({o_pll_mult, o_big_endian, o_boot_width, o_wdt_disable, o_pci_mode})
                && o_cfg_valid;
    endproperty
    a_stable: assert property (p_stable)
        else $error("decoded configuration changed after boot");

    property p_pll;
        @(posedge i_core_clk) disable iff (i_srst)
        release_now |=> o_pll_mult == $past(s_r.vec[PLL_LSB +: PLL_W])
            && s_r.rsvd[0] == (o_pll_mult != PLL_X2);
    endproperty
    a_pll: assert property (p_pll)
        else $error("PLL multiplier not decoded from vector");

    property p_endian;
        @(posedge i_core_clk) disable iff (i_srst)
        release_now ##1 1'b1 |-> o_big_endian == $past(s_r.vec[ENDIAN_BIT]);
    endproperty
    a_endian: assert property (p_endian)
        else $error("byte order not decoded from vector");

    property p_raw_read;
        @(posedge i_core_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == REG_RAW) |=> o_reg_rdata == DATA_W'($past(s_r.vec));
    endproperty
    a_raw_read: assert property (p_raw_read)
        else $error("raw vector read mismatch");

    property p_width;
        @(posedge i_core_clk) disable iff (i_srst)
        release_now |=> o_boot_width == $past(s_r.vec[WIDTH_LSB +: WIDTH_W])
            && s_r.rsvd[1] == (o_boot_width == WIDTH_RSVD);
    endproperty
    a_width: assert property (p_width)
        else $error("boot width not decoded from vector");

    property p_sysrst;
        @(posedge i_core_clk) disable iff (i_srst)
        (s_r.st != ST_RUN) |=> !o_system_reset_output_n [*8];
    endproperty
    a_sysrst: assert property (p_sysrst)
        else $error("system reset output not held after cold reset");

    property p_wdt;
        @(posedge i_core_clk) disable iff (i_srst)
        release_now |=> o_wdt_disable == $past(s_r.vec[WDT_BIT]);
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog disable not decoded from vector");

    property p_pci;
        @(posedge i_core_clk) disable iff (i_srst)
        release_now |=> o_pci_mode == $past(vec_pci) && s_r.rsvd[3] == (o_pci_mode > PCI_HOST_RR);
    endproperty
    a_pci: assert property (p_pci)
        else $error("PCI mode not decoded from vector");

    property p_pci_en;
        @(posedge i_core_clk) disable iff (i_srst)
        release_now |=> o_pci_en == ($past(vec_pci) == PCI_SAT_NRDY || $past(vec_pci) == PCI_SAT_SUSP);
    endproperty
    a_pci_en: assert property (p_pci_en)
        else $error("PCI enable boot value wrong");

    property p_cold_drop;
        @(posedge i_core_clk) disable iff (i_srst)
        !i_cold_reset_input_n |=> !o_cfg_valid;
    endproperty
    a_cold_drop: assert property (p_cold_drop)
        else $error("configuration still marked valid during cold reset");

    property p_sample_hold;
        @(posedge i_core_clk) disable iff (i_srst)
        (s_r.st == ST_SAMPLE && !i_cold_reset_input_n)
            |=> $stable({o_pll_mult, o_big_endian, o_boot_width, o_wdt_disable, o_pci_mode});
    endproperty
    a_sample_hold: assert property (p_sample_hold)
        else $error("decoded configuration moved while sampling");

    property p_raw_hold;
        @(posedge i_core_clk) disable iff (i_srst)
        (s_r.st == ST_RUN && i_cold_reset_input_n) |=> $stable(s_r.vec);
    endproperty
    a_raw_hold: assert property (p_raw_hold)
        else $error("raw vector changed after boot");

    property p_rstmode;
        @(posedge i_core_clk) disable iff (i_srst)
        release_now |=> s_r.rstmode == $past(s_r.vec[RSTMODE_BIT])
            && s_r.rsvd[2] == (s_r.rstmode == RSTMODE_RSVD);
    endproperty
    a_rstmode: assert property (p_rstmode)
        else $error("reset mode not decoded from vector");

    property p_pci_en_write;
        @(posedge i_core_clk) disable iff (i_srst)
        (i_reg_wr && i_reg_addr == REG_PCI_CTL && !release_now)
            |=> o_pci_en == $past(i_reg_wdata[PCI_EN_BIT]);
    endproperty
    a_pci_en_write: assert property (p_pci_en_write)
        else $error("PCI enable write did not land");

    property p_pci_en_keep;
        @(posedge i_core_clk) disable iff (i_srst)
        (!release_now && !(i_reg_wr && i_reg_addr == REG_PCI_CTL))
            |=> $stable(o_pci_en);
    endproperty
    a_pci_en_keep: assert property (p_pci_en_keep)
        else $error("PCI enable changed without boot or write");

    property p_cfg_read;
        @(posedge i_core_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == REG_CFG)
            |=> o_reg_rdata[PLL_LSB +: PLL_W] == $past(o_pll_mult)
                && o_reg_rdata[ENDIAN_BIT] == $past(o_big_endian) && o_reg_rdata[SPARE_LO_BIT] == 1'b0
                && o_reg_rdata[PCI_LSB +: PCI_W] == $past(o_pci_mode);
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("configuration read mismatch");

    property p_pci_ctl_read;
        @(posedge i_core_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == REG_PCI_CTL) |=> o_reg_rdata == DATA_W'($past(o_pci_en));
    endproperty
    a_pci_ctl_read: assert property (p_pci_ctl_read)
        else $error("PCI control read mismatch");

    property p_status_read;
        @(posedge i_core_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == REG_STATUS)
            |=> o_reg_rdata[ST_VALID_BIT] == $past(o_cfg_valid)
                && o_reg_rdata[ST_SYSRST_BIT] == !$past(o_system_reset_output_n);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read mismatch");

    property p_sysrst_run;
        @(posedge i_core_clk) disable iff (i_srst)
        (s_r.st == ST_RUN && i_cold_reset_input_n && o_system_reset_output_n)
            |=> o_system_reset_output_n;
    endproperty
    a_sysrst_run: assert property (p_sysrst_run)
        else $error("system reset output reasserted during operation");

endmodule : bsv_loader

// File: hw/bsv_pkg.sv
/*
 * Shared constants for the boot strap vector loader: vector field layout,
 * code points, register offsets, status bit positions and the state record.
 * Assumes a single core clock domain and a synchronous core reset.
 */
package bsv_pkg;

    localparam int VEC_W = 16;

    // Vector field positions
    localparam int PLL_LSB      = 0;
    localparam int PLL_W        = 3;
    localparam int ENDIAN_BIT   = 3;
    localparam int SPARE_LO_BIT = 4;
    localparam int WIDTH_LSB    = 5;
    localparam int WIDTH_W      = 2;
    localparam int RSTMODE_BIT  = 7;
    localparam int WDT_BIT      = 8;
    localparam int PCI_LSB      = 9;
    localparam int PCI_W        = 3;
    localparam int SPARE_HI_LSB = 12;

    // Code points
    localparam logic [PLL_W-1:0]   PLL_X2        = 3'h0;
    localparam logic [WIDTH_W-1:0] WIDTH_8       = 2'h0;
    localparam logic [WIDTH_W-1:0] WIDTH_16      = 2'h1;
    localparam logic [WIDTH_W-1:0] WIDTH_32      = 2'h2;
    localparam logic [WIDTH_W-1:0] WIDTH_RSVD    = 2'h3;
    localparam logic               RSTMODE_RSVD  = 1'h1;
    localparam logic [PCI_W-1:0]   PCI_OFF       = 3'h0;
    localparam logic [PCI_W-1:0]   PCI_SAT_NRDY  = 3'h1;
    localparam logic [PCI_W-1:0]   PCI_SAT_SUSP  = 3'h2;
    localparam logic [PCI_W-1:0]   PCI_HOST_EXT  = 3'h3;
    localparam logic [PCI_W-1:0]   PCI_HOST_FIX  = 3'h4;
    localparam logic [PCI_W-1:0]   PCI_HOST_RR   = 3'h5;

    // Register map, byte addresses
    localparam int               ADDR_W      = 4;
    localparam int               DATA_W      = 32;
    localparam logic [ADDR_W-1:0] REG_RAW     = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CFG     = 4'h4;
    localparam logic [ADDR_W-1:0] REG_PCI_CTL = 4'h8;
    localparam logic [ADDR_W-1:0] REG_STATUS  = 4'hC;

    // Field positions in control and status registers
    localparam int PCI_EN_BIT     = 0;
    localparam int ST_VALID_BIT   = 0;
    localparam int ST_RSVD_LSB    = 1;
    localparam int ST_SYSRST_BIT  = 5;

    // System reset stretch after cold reset, in core clock cycles
    localparam int RST_HOLD_CYCLES = 4096;
    localparam int RST_CNT_W       = 13;

    typedef enum logic [1:0] {
        ST_WAIT   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_RUN    = 2'b10
    } bsv_state_e;

    typedef struct packed {
        bsv_state_e         st;
        logic [VEC_W-1:0]   vec;
        logic [PLL_W-1:0]   pll;
        logic               big;
        logic [WIDTH_W-1:0] width;
        logic               rstmode;
        logic               wdt;
        logic [PCI_W-1:0]   pci;
        logic               pci_en;
        logic               valid;
        logic [3:0]         rsvd;
        logic [DATA_W-1:0]  rdata;
    } bsv_top_s;

    typedef struct packed {
        logic [RST_CNT_W-1:0] cnt;
        logic                 rst_n;
    } bsv_rst_s;

endpackage : bsv_pkg

// File: hw/bsv_rst_stretch.sv
/*
 * Stretches the system reset output: held low while i_hold is high and for
 * HOLD_CYCLES core clock cycles after i_hold falls.
 * Assumes i_hold is synchronous to i_core_clk.
 */
`timescale 1ns/100ps
module bsv_rst_stretch
    import bsv_pkg::*;
#(
    parameter logic [RST_CNT_W-1:0] HOLD_CYCLES = RST_CNT_W'(RST_HOLD_CYCLES)
) (
    input  wire logic i_core_clk,
    input  wire logic i_srst,
    input  wire logic i_hold,
    output logic      o_rst_n
);

    bsv_rst_s s_r;
    bsv_rst_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (i_hold) begin
            s_nxt.cnt   = '0;
            s_nxt.rst_n = 1'b0;
        end else if (!s_r.rst_n) begin
            if (s_r.cnt == HOLD_CYCLES - RST_CNT_W'(1)) begin
                s_nxt.rst_n = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + RST_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rst_n = s_r.rst_n;

    property p_hold_low;
        @(posedge i_core_clk) disable iff (i_srst)
        (!s_r.rst_n && s_r.cnt < HOLD_CYCLES - RST_CNT_W'(1)) |=> !o_rst_n;
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("system reset released before hold count");

    property p_release;
        @(posedge i_core_clk) disable iff (i_srst)
        (!i_hold && !s_r.rst_n && s_r.cnt == HOLD_CYCLES - RST_CNT_W'(1)) ##1 !i_hold
            |-> o_rst_n;
    endproperty
    a_release: assert property (p_release)
        else $error("system reset not released at end of hold");

endmodule : bsv_rst_stretch

// File: tb/bsv_strap_src.sv
/*
 * Board strap source model: drives the boot vector onto the strap bus
 * while cold reset is low and lets the bus churn once it is released.
 * Assumes the bench holds i_vec steady through each cold reset.
 */
`timescale 1ns/100ps
module bsv_strap_src
    import bsv_pkg::*;
(
    input  wire logic             i_core_clk,
    input  wire logic             i_cold_reset_input_n,
    input  wire logic [VEC_W-1:0] i_vec,
    output logic [VEC_W-1:0]      o_strap_data_bus
);
    logic [VEC_W-1:0] junk_r = 16'h5A3C;

    // Released bus changes every cycle so a late sample cannot match by luck
    always_ff @(posedge i_core_clk) begin
        junk_r <= junk_r + 16'h3B17;
    end

    assign o_strap_data_bus = i_cold_reset_input_n ? junk_r : i_vec;
endmodule : bsv_strap_src

// File: tb/tb_top.sv
/*
 * Self-checking bench for the boot strap vector loader: boots every PCI
 * mode code, checks decode, register view, PCI enable and reset stretch.
 * Assumes a short reset stretch parameter to keep the run brief.
 */
`timescale 1ns/100ps
module tb_top;
    import bsv_pkg::*;

    localparam int HOLD = 8;

    logic              clk    = 1'b0;
    logic              srst   = 1'b1;
    logic              cold_n = 1'b1;
    logic              wr     = 1'b0;
    logic              rd     = 1'b0;
    logic [ADDR_W-1:0] addr   = '0;
    logic [DATA_W-1:0] wdata  = '0;
    logic [VEC_W-1:0]  vec    = '0;
    logic [VEC_W-1:0]  prev   = '0;
    logic [VEC_W-1:0]  v;
    logic [VEC_W-1:0]  bus;
    logic [DATA_W-1:0] rdata;
    logic [PLL_W-1:0]  pll;
    logic              big;
    logic [WIDTH_W-1:0] width;
    logic              wdt;
    logic [PCI_W-1:0]  pci;
    logic              pci_en;
    logic              valid;
    logic              sys_n;
    int                bad_count = 0;
    int                tests_run = 0;

    always #5 clk = ~clk;

    bsv_strap_src i_src (
        .i_core_clk          (clk),
        .i_cold_reset_input_n(cold_n),
        .i_vec               (vec),
        .o_strap_data_bus    (bus)
    );

    bsv_loader #(.HOLD_CYCLES(HOLD)) i_dut (
        .i_core_clk             (clk),
        .i_srst                 (srst),
        .i_cold_reset_input_n   (cold_n),
        .i_strap_data_bus       (bus),
        .i_reg_addr             (addr),
        .i_reg_wdata            (wdata),
        .i_reg_wr               (wr),
        .i_reg_rd               (rd),
        .o_reg_rdata            (rdata),
        .o_pll_mult             (pll),
        .o_big_endian           (big),
        .o_boot_width           (width),
        .o_wdt_disable          (wdt),
        .o_pci_mode             (pci),
        .o_pci_en               (pci_en),
        .o_cfg_valid            (valid),
        .o_system_reset_output_n(sys_n)
    );

    task automatic stop_test;
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : reg_rd

    // Cold reset with vector v; checks hold of old config and the stretch
    task automatic boot(input logic [VEC_W-1:0] bv);
        int n;
        @(posedge clk);
        cold_n <= 1'b0;
        vec    <= bv;
        repeat (2) @(posedge clk);
        #1 chk(valid, 1'b0);
        chk(pci, prev[11:9]);
        @(posedge clk);
        cold_n <= 1'b1;
        n = 0;
        while (valid !== 1'b1 && n < 6) begin
            @(posedge clk);
            #1 n++;
        end
        chk(n, 1);
        chk(sys_n, 1'b0);
        n = 0;
        while (sys_n !== 1'b1 && n < HOLD + 5) begin
            @(posedge clk);
            #1 n++;
        end
        chk(n, HOLD);
    endtask : boot

    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        for (int m = 0; m < 8; m++) begin
            v = {4'(m + 9), 3'(m), m[0], m[2] & m[1], 2'(m), m[2], m[1], (m == 7) ? 3'h5 : 3'h0};
            boot(v);
            chk(pll, v[2:0]);
            chk(big, v[3]);
            chk(width, v[6:5]);
            chk(wdt, v[8]);
            chk(pci, v[11:9]);
            chk(pci_en, (m == 1 || m == 2));
            chk(valid, 1'b1);
            reg_rd(REG_RAW, 32'(v));
            reg_rd(REG_CFG, {20'h0, v[11:5], 1'b0, v[3:0]});
            reg_rd(REG_STATUS, {26'h0, 1'b0, m >= 6, v[7], v[6:5] == 2'h3, v[2:0] != 3'h0, 1'b1});
            reg_rd(REG_PCI_CTL, 32'(m == 1 || m == 2));
            reg_wr(REG_PCI_CTL, 32'(!(m == 1 || m == 2)));
            #1 chk(pci_en, !(m == 1 || m == 2));
            reg_wr(REG_RAW, 32'hFFFF_FFFF);
            reg_rd(REG_RAW, 32'(v));
            reg_rd(4'h2, 32'h0);
            prev = v;
        end
        // A core reset alone leaves no configuration behind
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(valid, 1'b0);
        chk(pci_en, 1'b0);
        chk(sys_n, 1'b0);
        prev = '0;
        v    = 16'hC328;
        boot(v);
        chk(big, 1'b1);
        chk(width, 2'h1);
        chk(pci_en, 1'b1);
        reg_rd(REG_RAW, 32'h0000_C328);
        stop_test();
    end

    // Nine boots take a few hundred cycles; this is far beyond that
    initial begin
        #100000;
        bad_count++;
        stop_test();
    end
endmodule : tb_top
